// ==== src/rtk_pkg.sv ====
// Shared constants for the I2C real-time clock block
package rtk_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SEC  = 8'h00;
  localparam logic [7:0] REG_MIN  = 8'h01;
  localparam logic [7:0] REG_HRS  = 8'h02;
  localparam logic [7:0] REG_DAY  = 8'h03;
  localparam logic [7:0] REG_DATE = 8'h04;
  localparam logic [7:0] REG_MON  = 8'h05;
  localparam logic [7:0] REG_YEAR = 8'h06;
  localparam logic [7:0] REG_CAL  = 8'h07;
  localparam logic [7:0] REG_CHG  = 8'h08;
  localparam logic [7:0] REG_CONFIG_TWO = 8'h09;
  localparam logic [7:0] REG_KEY1 = 8'h14;
  localparam logic [7:0] REG_KEY2 = 8'h15;
  localparam logic [7:0] REG_SFR  = 8'h16;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEC_HALT_BIT  = 7;
  localparam int MIN_FAIL_BIT  = 7;
  localparam int HRS_CENTEN_BIT = 7;
  localparam int HRS_CENT_BIT  = 6;
  localparam int CAL_OUT_BIT   = 7;
  localparam int CAL_FT_BIT    = 6;
  localparam int CAL_SIGN_BIT  = 5;
  localparam int CHG_CHARGE_ENABLE_BIT  = 5;
  localparam int CONFIG_TWO_KEY_LSB  = 4;
  localparam int CONFIG_TWO_BYP_BIT  = 0;
  localparam int SFR_FTF_BIT   = 0;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SEC_RST  = 8'h00;
  localparam logic [7:0] MIN_RST  = 8'h80;
  localparam logic [7:0] DMY_RST  = 8'h01;
  localparam logic [7:0] CAL_RST  = 8'h80;
  localparam logic [3:0] CHARGE_KEY = 4'h5;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int OSC_PERIOD_NS  = 30518;
  localparam int OSC_MISS_PULSES = 4;
  localparam int OSC_MISS_CYCLES =
    (OSC_MISS_PULSES * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_DIV_BITS   = 6;
  localparam int STEPS_PER_SEC  = 512;
  localparam int CAL_SLOW_MIN   = 16;
  localparam int CAL_FAST_MIN   = 8;
  localparam int CAL_SLOW_SECS  = CAL_SLOW_MIN * 60;
  localparam int CAL_FAST_SECS  = CAL_FAST_MIN * 60;
endpackage

// ==== src/rtk_top.sv ====
// Real-time clock core with I2C slave port and oscillator domain
`timescale 1ns/100ps
module rtk_top
  import rtk_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic osc_clk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      cfg_pin_o,
  output logic      cfg_pin_oe,
  input  wire logic vcc_below_vback,
  input  wire logic vcc_below_vref,
  output logic      on_backup,
  output logic      charge_sw_main,
  output logic      charge_sw_aux,
  output logic      charge_sw_bypass
);
  import rtk_pkg::*;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    I_IDLE = 7'b0000001,
    I_ADDR = 7'b0000010,
    I_AACK = 7'b0000100,
    I_WR   = 7'b0001000,
    I_WACK = 7'b0010000,
    I_RD   = 7'b0100000,
    I_RACK = 7'b1000000
  } rtk_i2c_e;

  typedef struct packed {
    logic                    halt_m;
    logic                    halt_s;
    logic [OSC_DIV_BITS-1:0] div;
    logic                    step_tog;
  } rtk_osc_s;

  typedef struct packed {
    logic       scl_m, scl_s, scl_d;
    logic       sda_m, sda_s, sda_d;
    logic       vb_m, vb_s, vr_m, vr_s;
    logic       backup;
    logic       tg_m, tg_s, tg_d;
    logic       w_m, w_s;
    logic       o_m, o_s, o_d;
    logic [10:0] miss;
    logic [9:0] step;
    logic [9:0] secs;
    logic [7:0] sec, min, hrs, day, date, mon, year;
    logic [7:0] cal, chg, config_two, key1, key2, special_function_ctl;
    rtk_i2c_e   st;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [7:0] ptr;
    logic       first;
    logic       rnw;
    logic       sda_oe;
    logic       pin_oe;
    logic       sw_main, sw_aux, sw_byp;
  } rtk_core_s;

  localparam logic [10:0] MISS_MAX = 11'(OSC_MISS_CYCLES);
  localparam logic [9:0]  STEPS    = 10'(STEPS_PER_SEC);
  localparam logic [9:0]  SLOW_S   = 10'(CAL_SLOW_SECS);
  localparam logic [9:0]  FAST_S   = 10'(CAL_FAST_SECS);

  rtk_osc_s  o, next_o;
  rtk_core_s r, next_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // BCD step; out-of-range values below hi keep counting until they hit hi
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    if (v == hi)
      bcd_inc = {1'b1, lo};
    else if (v[3:0] >= 4'h9)
      bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {1'b0, v + 8'h01};
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:   last_day = is_leap(y) ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input rtk_core_s c, input logic [7:0] a);
    case (a)
      REG_SEC:  reg_read = c.sec;
      REG_MIN:  reg_read = c.min;
      REG_HRS:  reg_read = c.hrs;
      REG_DAY:  reg_read = c.day;
      REG_DATE: reg_read = c.date;
      REG_MON:  reg_read = c.mon;
      REG_YEAR: reg_read = c.year;
      REG_CAL:  reg_read = c.cal;
      REG_CHG:  reg_read = c.chg;
      REG_CONFIG_TWO: reg_read = c.config_two;
      REG_KEY1: reg_read = c.key1;
      REG_KEY2: reg_read = c.key2;
      REG_SFR:  reg_read = c.special_function_ctl;
      default:  reg_read = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Oscillator domain
  // ----------------------------------------------------------------
  // Only a 64:1 prescaler lives here; the slow second count and the
  // calibration run on clk, so no multi-bit word crosses domains.
  always_comb
  begin
    next_o = o;
    next_o.halt_m = r.sec[SEC_HALT_BIT];
    next_o.halt_s = o.halt_m;
    if (!o.halt_s)
    begin
      next_o.div = o.div + 1'b1;
      if (&o.div)
        next_o.step_tog = ~o.step_tog;
    end
  end

  always_ff @(posedge osc_clk or negedge reset_n)
  begin
    if (!reset_n)
      o <= '0;
    else
      o <= next_o;
  end

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  logic [8:0] c_sec, c_min, c_hrs, c_day, c_date, c_mon, c_year;
  logic       step_evt, sec_evt, adj_now, hz1, wave, bk_now;
  logic       scl_rise, scl_fall, i2c_start, i2c_stop, chg_ok;
  logic [9:0] target;
  logic [9:0] interval;
  logic [7:0] rd;

  always_comb
  begin
    next_r = r;
    // Synchronisers
    next_r.scl_m = scl_i;
    next_r.scl_s = r.scl_m;
    next_r.scl_d = r.scl_s;
    next_r.sda_m = sda_i;
    next_r.sda_s = r.sda_m;
    next_r.sda_d = r.sda_s;
    next_r.vb_m  = vcc_below_vback;
    next_r.vb_s  = r.vb_m;
    next_r.vr_m  = vcc_below_vref;
    next_r.vr_s  = r.vr_m;
    next_r.tg_m  = o.step_tog;
    next_r.tg_s  = r.tg_m;
    next_r.tg_d  = r.tg_s;
    next_r.w_m   = o.div[OSC_DIV_BITS-1];
    next_r.w_s   = r.w_m;
    next_r.o_m   = o.div[0];
    next_r.o_s   = r.o_m;
    next_r.o_d   = r.o_s;

    // Supply switchover
    bk_now = r.vb_s & r.vr_s;
    next_r.backup = bk_now;
    if (bk_now && !r.backup)
    begin
      next_r.chg[CHG_CHARGE_ENABLE_BIT] = 1'b0;
      next_r.config_two = 8'h00;
    end
    if (!bk_now && r.backup)
    begin
      next_r.cal[CAL_FT_BIT]  = 1'b0;
      next_r.special_function_ctl[SFR_FTF_BIT] = 1'b0;
    end

    // Second generation with calibration
    interval = r.cal[CAL_SIGN_BIT] ? FAST_S : SLOW_S;
    adj_now  = (r.secs >= interval - 10'd1);
    if (!adj_now)
      target = STEPS;
    else if (r.cal[CAL_SIGN_BIT])
      target = STEPS - {5'h00, r.cal[4:0]};
    else
      target = STEPS + {5'h00, r.cal[4:0]};
    step_evt = r.tg_s ^ r.tg_d;
    sec_evt  = step_evt && (r.step + 10'd1 >= target);
    if (step_evt)
      next_r.step = sec_evt ? 10'd0 : r.step + 10'd1;
    if (sec_evt)
      next_r.secs = adj_now ? 10'd0 : r.secs + 10'd1;
    hz1  = (r.step < (STEPS >> 1));
    wave = r.w_s;

    // Time chain, all fields in one cycle
    c_sec  = bcd_inc({1'b0, r.sec[6:0]}, 8'h00, 8'h59);
    c_min  = bcd_inc({1'b0, r.min[6:0]}, 8'h00, 8'h59);
    c_hrs  = bcd_inc({2'b00, r.hrs[5:0]}, 8'h00, 8'h23);
    c_day  = bcd_inc({5'h00, r.day[2:0]}, 8'h01, 8'h07);
    c_date = bcd_inc({2'b00, r.date[5:0]}, 8'h01, last_day(r.mon, r.year));
    c_mon  = bcd_inc({3'b000, r.mon[4:0]}, 8'h01, 8'h12);
    c_year = bcd_inc(r.year, 8'h00, 8'h99);
    if (sec_evt)
    begin
      next_r.sec[6:0] = c_sec[6:0];
      if (c_sec[8])
      begin
        next_r.min[6:0] = c_min[6:0];
        if (c_min[8])
        begin
          next_r.hrs[5:0] = c_hrs[5:0];
          if (c_hrs[8])
          begin
            next_r.day[2:0]  = c_day[2:0];
            next_r.date[5:0] = c_date[5:0];
            if (c_date[8])
            begin
              next_r.mon[4:0] = c_mon[4:0];
              if (c_mon[8])
              begin
                next_r.year = c_year[7:0];
                if (c_year[8] && r.hrs[HRS_CENTEN_BIT])
                  next_r.hrs[HRS_CENT_BIT] = ~r.hrs[HRS_CENT_BIT];
              end
            end
          end
        end
      end
    end

    // I2C slave
    scl_rise  = r.scl_s & ~r.scl_d;
    scl_fall  = ~r.scl_s & r.scl_d;
    i2c_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
    i2c_stop  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
    rd = reg_read(r, r.ptr);
    if (i2c_start)
    begin
      next_r.st = I_ADDR;
      next_r.bitc = 4'h0;
      next_r.sda_oe = 1'b0;
    end
    else if (i2c_stop)
    begin
      next_r.st = I_IDLE;
      next_r.sda_oe = 1'b0;
    end
    else
    begin
      case (r.st)
        I_IDLE:
          next_r.sda_oe = 1'b0;
        I_ADDR, I_WR:
        begin
          if (scl_rise)
          begin
            next_r.sh = {r.sh[6:0], r.sda_s};
            next_r.bitc = r.bitc + 4'h1;
          end
          if (scl_fall && r.bitc == 4'h8)
          begin
            if (r.st == I_WR)
            begin
              next_r.sda_oe = 1'b1;
              next_r.st = I_WACK;
            end
            else if (r.sh[7:1] == SLAVE_ADDR)
            begin
              next_r.sda_oe = 1'b1;
              next_r.rnw = r.sh[0];
              next_r.st = I_AACK;
            end
            else
              next_r.st = I_IDLE;
          end
        end
        I_AACK:
          if (scl_fall)
          begin
            next_r.bitc = 4'h0;
            if (r.rnw)
            begin
              next_r.sh = rd;
              next_r.sda_oe = ~rd[7];
              next_r.st = I_RD;
            end
            else
            begin
              next_r.sda_oe = 1'b0;
              next_r.first = 1'b1;
              next_r.st = I_WR;
            end
          end
        I_WACK:
          if (scl_fall)
          begin
            next_r.sda_oe = 1'b0;
            next_r.bitc = 4'h0;
            next_r.st = I_WR;
            next_r.first = 1'b0;
            if (r.first)
              next_r.ptr = r.sh;
            else
            begin
              next_r.ptr = r.ptr + 8'h01;
              case (r.ptr)
                REG_SEC:  next_r.sec = r.sh;
                REG_MIN:  next_r.min = r.sh;
                REG_HRS:  next_r.hrs = r.sh;
                REG_DAY:  next_r.day = {5'h00, r.sh[2:0]};
                REG_DATE: next_r.date = {2'b00, r.sh[5:0]};
                REG_MON:  next_r.mon = {3'b000, r.sh[4:0]};
                REG_YEAR: next_r.year = r.sh;
                REG_CAL:  next_r.cal = r.sh;
                REG_CHG:  next_r.chg = r.sh;
                REG_CONFIG_TWO: next_r.config_two = r.sh;
                REG_KEY1: next_r.key1 = r.sh;
                REG_KEY2: next_r.key2 = r.sh;
                REG_SFR:  next_r.special_function_ctl = r.sh;
                default:  next_r.ptr = r.ptr + 8'h01;
              endcase
            end
          end
        I_RD:
          if (scl_fall)
          begin
            if (r.bitc == 4'h7)
            begin
              next_r.sda_oe = 1'b0;
              next_r.ptr = r.ptr + 8'h01;
              next_r.st = I_RACK;
            end
            else
            begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.sda_oe = ~r.sh[6];
              next_r.bitc = r.bitc + 4'h1;
            end
          end
        I_RACK:
        begin
          // Master NACK ends the burst; we wait for stop or start
          if (scl_rise && r.sda_s)
            next_r.st = I_IDLE;
          else if (scl_fall)
          begin
            next_r.sh = rd;
            next_r.sda_oe = ~rd[7];
            next_r.bitc = 4'h0;
            next_r.st = I_RD;
          end
        end
        default:
        begin
          next_r.st = I_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end

    // Oscillator fail detect; hardware set beats a clearing write
    if (r.o_s ^ r.o_d)
      next_r.miss = 11'd0;
    else if (r.miss < MISS_MAX)
      next_r.miss = r.miss + 11'd1;
    if (r.miss == MISS_MAX - 11'd1)
      next_r.min[MIN_FAIL_BIT] = 1'b1;

    // Output pin, open drain: enable pulls low
    if (r.cal[CAL_FT_BIT])
      next_r.pin_oe = ~(r.special_function_ctl[SFR_FTF_BIT] ? hz1 : wave);
    else
      next_r.pin_oe = ~r.cal[CAL_OUT_BIT];
    if (bk_now)
      next_r.pin_oe = 1'b0;

    // Charge switches
    chg_ok = (r.config_two[CONFIG_TWO_KEY_LSB+3:CONFIG_TWO_KEY_LSB] == CHARGE_KEY)
             && r.chg[CHG_CHARGE_ENABLE_BIT] && !bk_now;
    next_r.sw_main = chg_ok;
    next_r.sw_aux  = chg_ok;
    next_r.sw_byp  = chg_ok && r.config_two[CONFIG_TWO_BYP_BIT];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r       <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
      r.st    <= I_IDLE;
      r.sec   <= SEC_RST;
      r.min   <= MIN_RST;
      r.day   <= DMY_RST;
      r.date  <= DMY_RST;
      r.mon   <= DMY_RST;
      r.cal   <= CAL_RST;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data and pin levels are always low; only the enables move
  assign sda_o            = r.first & 1'b0;
  assign sda_oe           = r.sda_oe;
  assign cfg_pin_o        = r.rnw & 1'b0;
  assign cfg_pin_oe       = r.pin_oe;
  assign on_backup        = r.backup;
  assign charge_sw_main   = r.sw_main;
  assign charge_sw_aux    = r.sw_aux;
  assign charge_sw_bypass = r.sw_byp;
endmodule

// ==== verification/rtk_monitor.sv ====
// Bound checker for the real-time clock pins
`timescale 1ns/100ps
module rtk_monitor
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic cfg_pin_o,
  input wire logic cfg_pin_oe,
  input wire logic vcc_below_vback,
  input wire logic vcc_below_vref,
  input wire logic on_backup,
  input wire logic charge_sw_main,
  input wire logic charge_sw_aux,
  input wire logic charge_sw_bypass
);
  wire logic any_sw = charge_sw_main || charge_sw_aux || charge_sw_bypass;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Two sync stages plus a register, so five cycles leaves margin
  sequence both_low_s;
    vcc_below_vback && vcc_below_vref;
  endsequence
  sequence backup_held_s;
    on_backup [*3];
  endsequence
  pins_low_a: assert property (!sda_o && !cfg_pin_o)
    else $error("open-drain value not low");
  enter_backup_a: assert property (both_low_s [*5] |-> on_backup)
    else $error("backup not entered");
  stay_main_a: assert property ((!(vcc_below_vback && vcc_below_vref)) [*5] |-> !on_backup)
    else $error("backup without both comparators");
  pin_off_a: assert property (backup_held_s |-> !cfg_pin_oe)
    else $error("config pin driven on backup");
  charge_open_a: assert property (backup_held_s |-> !any_sw)
    else $error("charge switch closed on backup");
  ack_low_phase_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed with clock high");
  ack_steady_a: assert property ($rose(scl_i) |=> $stable(sda_oe) [*3])
    else $error("data drive unstable in clock high");
  reset_idle_a: assert property ($rose(reset_n) |-> !cfg_pin_oe && !sda_oe && !on_backup)
    else $error("pins not idle after reset");
endmodule

bind rtk_top rtk_monitor mon_u
(
  .clk(clk), .reset_n(reset_n), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .cfg_pin_o(cfg_pin_o), .cfg_pin_oe(cfg_pin_oe), .vcc_below_vback(vcc_below_vback),
  .vcc_below_vref(vcc_below_vref), .on_backup(on_backup), .charge_sw_main(charge_sw_main),
  .charge_sw_aux(charge_sw_aux), .charge_sw_bypass(charge_sw_bypass)
);

// ==== verification/rtk_i2c_master.sv ====
// Behavioural I2C bus master facing the clock's serial port
`timescale 1ns/100ps
module rtk_i2c_master
(
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  int half = 10;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(half);
    scl = 1'b1;
    tick(half);
    r = sda;
    scl = 1'b0;
    tick(2); // Hold data past the falling clock
  endtask
  task automatic start();
    sda_low = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_low = 1'b1;
    tick(half);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_low = 1'b0;
    tick(half);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
  task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    start();
    send(8'hD0, a);
    send(ptr, a);
    foreach (d[i])
      send(d[i], a);
    stop();
  endtask
  task automatic rd_regs(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
    logic       a;
    logic [7:0] b;
    q = {};
    start();
    send(8'hD0, a);
    send(ptr, a);
    start();
    send(8'hD1, a);
    for (int i = 0; i < n; i++)
    begin
      recv(b, i == n - 1);
      q.push_back(b);
    end
    stop();
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the I2C real-time clock
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, reset_n = 0, osc_clk = 0, osc_run = 1, vb = 0, vr = 0;
  logic sda_o, sda_oe, cfg_pin_o, cfg_pin_oe, on_backup, sw_m, sw_a, sw_b, scl, m_low;
  wire  sda = !(sda_oe || m_low);
  wire  cfg_pin = !cfg_pin_oe;
  int   num_errors = 0;
  int   checks = 0;
  always #50 clk = ~clk;
  always #32 if (osc_run) osc_clk = ~osc_clk;
  rtk_top dut_u
  (
    .clk(clk), .reset_n(reset_n), .osc_clk(osc_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cfg_pin_o(cfg_pin_o), .cfg_pin_oe(cfg_pin_oe),
    .vcc_below_vback(vb), .vcc_below_vref(vr), .on_backup(on_backup),
    .charge_sw_main(sw_m), .charge_sw_aux(sw_a), .charge_sw_bypass(sw_b)
  );
  rtk_i2c_master mst_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk_regs(input logic [7:0] ptr, input logic [7:0] e[$]);
    logic [7:0] q[$];
    mst_u.rd_regs(ptr, e.size(), q);
    foreach (e[i])
      chk(q[i], e[i]);
  endtask
  task automatic rises(output int n);
    logic prev;
    n = 0;
    prev = cfg_pin;
    repeat (410)
    begin
      tick(1);
      if (cfg_pin && !prev)
        n++;
      prev = cfg_pin;
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_regs(8'h00, '{8'h00, 8'h80, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00});
    chk_regs(8'h14, '{8'h00, 8'h00, 8'h00});
    chk_bit(cfg_pin, 1'b1);
  endtask
  task automatic t_addr();
    logic       a;
    logic [7:0] b;
    logic [7:0] adr[4] = '{8'h00, 8'hA0, 8'hD0, 8'hD1};
    logic       ack_exp[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      mst_u.start();
      mst_u.send(adr[i], a);
      chk_bit(a, ack_exp[i]);
      if (a && adr[i][0])
        mst_u.recv(b, 1'b1);
      mst_u.stop();
    end
    mst_u.wr_regs(8'h0B, '{8'h5A});
    chk_regs(8'h0B, '{8'h00});
  endtask
  task automatic t_burst();
    logic a;
    mst_u.half = 25; // Slow master
    mst_u.wr_regs(8'h14, '{8'hAA, 8'h55, 8'h01});
    mst_u.half = 10;
    chk_regs(8'h14, '{8'hAA, 8'h55, 8'h01});
    mst_u.start();
    mst_u.send(8'hD0, a);
    mst_u.send(8'h15, a);
    repeat (4) mst_u.bit_io(1'b1, a);
    mst_u.stop();
    chk_regs(8'h15, '{8'h55});
  endtask
  task automatic t_pin();
    int n;
    mst_u.wr_regs(8'h07, '{8'h00});
    tick(8);
    chk_bit(cfg_pin, 1'b0);
    mst_u.wr_regs(8'h16, '{8'h00});
    mst_u.wr_regs(8'h07, '{8'hC0});
    rises(n);
    chk_bit(n inside {[9:11]}, 1'b1);
    mst_u.wr_regs(8'h16, '{8'h01});
    rises(n);
    chk_bit(n < 2, 1'b1);
  endtask
  task automatic t_backup();
    mst_u.wr_regs(8'h07, '{8'h40});
    mst_u.wr_regs(8'h08, '{8'h20, 8'h40});
    tick(8);
    chk_bit(sw_m, 1'b0);
    mst_u.wr_regs(8'h09, '{8'h50});
    tick(8);
    chk({5'h00, sw_m, sw_a, sw_b}, 8'h06);
    mst_u.wr_regs(8'h09, '{8'h51});
    tick(8);
    chk({5'h00, sw_m, sw_a, sw_b}, 8'h07);
    vr = 1'b1;
    tick(10);
    chk_bit(on_backup, 1'b0);
    vb = 1'b1;
    tick(10);
    chk({4'h0, on_backup, sw_m, sw_a, sw_b}, 8'h08);
    chk_bit(cfg_pin, 1'b1);
    vr = 1'b0;
    tick(10);
    chk_bit(on_backup, 1'b0);
    tick(600);
    chk_regs(8'h07, '{8'h00});
    chk_regs(8'h08, '{8'h00, 8'h00});
    chk_regs(8'h16, '{8'h00});
    chk_bit(cfg_pin, 1'b0);
  endtask
  task automatic t_fail();
    mst_u.wr_regs(8'h01, '{8'h00});
    chk_regs(8'h01, '{8'h00});
    osc_run = 1'b0;
    tick(1400);
    osc_run = 1'b1;
    chk_regs(8'h01, '{8'h80});
    // Halt, then clear the flag before the miss timeout runs out
    mst_u.wr_regs(8'h00, '{8'h80, 8'h00});
    tick(1400);
    chk_regs(8'h00, '{8'h80, 8'h80});
    mst_u.wr_regs(8'h00, '{8'h00, 8'h00});
    tick(1400);
    chk_regs(8'h01, '{8'h00});
  endtask
  task automatic t_roll(input logic [7:0] yr, input logic [7:0] dt, input logic [7:0] mo);
    logic [7:0] q[$];
    // Seconds last, so no carry can land in the middle of the burst
    mst_u.wr_regs(8'h01, '{8'h59, 8'h23, 8'h07, 8'h28, 8'h02, yr});
    mst_u.wr_regs(8'h00, '{8'h59});
    for (int i = 0; i < 40; i++)
    begin
      mst_u.rd_regs(8'h00, 1, q);
      if (q[0] !== 8'h59)
        break;
    end
    chk_regs(8'h00, '{8'h00, 8'h00, 8'h00, 8'h01, dt, mo, yr});
  endtask
  initial
  begin
    tick(16);
    reset_n = 1'b1;
    tick(4);
    t_reset();
    t_addr();
    t_burst();
    t_pin();
    t_backup();
    t_fail();
    t_roll(8'h24, 8'h29, 8'h02);
    t_roll(8'h23, 8'h01, 8'h03);
    results();
  end
  // Two worst-case rollovers dominate the run time
  initial
  begin
    repeat (98000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
